/* File: logic/cplc_defines.svh */
// constants for the charge pump level controller
// assumes a 20 MHz clock and the byte-wide register port of the codec
//Contract
//- pump runs only while enable bit set
//- low-load power-save bit, resets enabled
//- mode 00 takes level from manual field
//- mode 01 follows largest output volume
//- mode 10 follows converter volume, reset mode
//- mode 11 follows signal magnitude
//- manual: standby, reserved, half, full
//- decay code sets full-to-half delay
//- rate code sets nominal switching rate
//- code 101 stops clock, analog only
//- half threshold used in modes 10, 11
`ifndef CPLC_DEFINES_SVH
`define CPLC_DEFINES_SVH
`define CPLC_CLK_HZ        20000000
`define CPLC_MS_CYCLES     (`CPLC_CLK_HZ / 1000)
`define CPLC_ADDR_CTRL     8'hac
`define CPLC_ADDR_DLY      8'had
`define CPLC_ADDR_THR      8'hae
`define CPLC_CTRL_RST      8'h60
`define CPLC_DLY_RST       8'h11
`define CPLC_THR_RST       8'h0e
`define CPLC_CTRL_MASK     8'hfc
`define CPLC_DLY_MASK      8'h3f
`define CPLC_THR_MASK      8'h3f
`define CPLC_CTRL_EN_BIT   7
`define CPLC_CTRL_LP_BIT   6
`define CPLC_CTRL_MODE_LSB 4
`define CPLC_CTRL_MAN_LSB  2
`define CPLC_DLY_DECAY_LSB 3
`define CPLC_DLY_RATE_LSB  0
`define CPLC_THR_LSB       0
`define CPLC_OUT_THR_DEF   6'h0e
`define CPLC_RATE_STOP     3'h5
`define CPLC_RATE0_KHZ     1000
`define CPLC_RATE1_KHZ     500
`define CPLC_RATE2_KHZ     250
`define CPLC_RATE3_KHZ     125
`define CPLC_RATE4_KHZ     63
`define CPLC_DECAY0_MS     0
`define CPLC_DECAY1_MS     2
`define CPLC_DECAY2_MS     4
`define CPLC_DECAY3_MS     16
`define CPLC_DECAY4_MS     64
`define CPLC_DECAY5_MS     128
`define CPLC_DECAY6_MS     256
`define CPLC_DECAY7_MS     512
`endif

/* File: logic/cplc_pkg.sv */
// types for the charge pump level controller
// assumes cplc_defines.svh supplies all numbers
package cplc_pkg;
  typedef enum logic [1:0] {
    CPLC_MANUAL  = 2'h0,
    CPLC_TRK_OUT = 2'h1,
    CPLC_TRK_DAC = 2'h2,
    CPLC_TRK_MAG = 2'h3
  } cplc_mode_t;

  typedef enum logic [1:0] {
    CPLC_LVL_STBY = 2'h0,
    CPLC_LVL_RSVD = 2'h1,
    CPLC_LVL_HALF = 2'h2,
    CPLC_LVL_FULL = 2'h3
  } cplc_level_t;

  typedef enum logic [1:0] {
    CPLC_ST_STBY  = 2'h0,
    CPLC_ST_HALF  = 2'h1,
    CPLC_ST_FULL  = 2'h3,
    CPLC_ST_DECAY = 2'h2
  } cplc_state_t;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  dly;
    logic [7:0]  thr;
    logic [7:0]  rdata;
    cplc_state_t state;
    logic [23:0] pre;
    logic [9:0]  ms_left;
  } cplc_regs_t;

  typedef struct packed {
    logic [9:0] cnt;
    logic       tick;
  } cplc_div_t;
endpackage : cplc_pkg

/* File: logic/cplc_rate_div.sv */
// switching clock divider for the charge pump
// assumes run and rate_sel come from flops on clk
`timescale 1ns/100ps
`default_nettype none
`include "cplc_defines.svh"
module cplc_rate_div import cplc_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       run,
  input  wire logic [2:0] rate_sel,
  output logic            tick
);
  cplc_div_t  st;
  cplc_div_t  next_st;
  logic [9:0] div;

  function automatic logic [9:0] divisor(input logic [2:0] code);
    case (code)
      3'h0: divisor = 10'(`CPLC_MS_CYCLES / `CPLC_RATE0_KHZ);
      3'h1: divisor = 10'(`CPLC_MS_CYCLES / `CPLC_RATE1_KHZ);
      3'h2: divisor = 10'(`CPLC_MS_CYCLES / `CPLC_RATE2_KHZ);
      3'h3: divisor = 10'(`CPLC_MS_CYCLES / `CPLC_RATE3_KHZ);
      3'h4: divisor = 10'(`CPLC_MS_CYCLES / `CPLC_RATE4_KHZ);
      default: divisor = 10'h0;
    endcase
  endfunction : divisor

  assign div = divisor(rate_sel);

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run || div == 10'h0) begin
      next_st.cnt = 10'h0;
    end else if (st.cnt >= div - 10'h1) begin
      // a rate change to a divisor at or below the count reached ends the period at once, never overruns
      next_st.cnt = 10'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 10'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{cnt: 10'h0, tick: 1'b0};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule : cplc_rate_div
`default_nettype wire

/* File: logic/cplc_pump_ctrl.sv */
// charge pump level controller: registers, level state machine, decay timer
// assumes register port and volume inputs are driven from logic on clk
`timescale 1ns/100ps
`default_nettype none
`include "cplc_defines.svh"
module cplc_pump_ctrl import cplc_pkg::*; #(
  parameter int         MS_CYCLES   = `CPLC_MS_CYCLES,
  parameter logic [5:0] OUT_VOL_THR = `CPLC_OUT_THR_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [5:0] out_vol_max,
  input  wire logic [5:0] dac_vol,
  input  wire logic [5:0] sig_mag,
  output logic            pump_run,
  output logic            low_load_power_save,
  output logic      [1:0] pump_level,
  output logic            switch_tick,
  output logic            analog_only
);
  cplc_regs_t  st;
  cplc_regs_t  next_st;
  cplc_mode_t  mode;
  cplc_level_t man;
  logic        pump_en;
  logic [2:0]  rate_sel;
  logic [2:0]  decay_sel;
  logic [5:0]  half_thr;
  logic [9:0]  decay_ms;
  logic        want_full;
  logic        want_half;
  logic        ms_tick;

  function automatic logic [9:0] decay_lookup(input logic [2:0] code);
    case (code)
      3'h0: decay_lookup = 10'(`CPLC_DECAY0_MS);
      3'h1: decay_lookup = 10'(`CPLC_DECAY1_MS);
      3'h2: decay_lookup = 10'(`CPLC_DECAY2_MS);
      3'h3: decay_lookup = 10'(`CPLC_DECAY3_MS);
      3'h4: decay_lookup = 10'(`CPLC_DECAY4_MS);
      3'h5: decay_lookup = 10'(`CPLC_DECAY5_MS);
      3'h6: decay_lookup = 10'(`CPLC_DECAY6_MS);
      default: decay_lookup = 10'(`CPLC_DECAY7_MS);
    endcase
  endfunction : decay_lookup

  assign pump_en   = st.ctrl[`CPLC_CTRL_EN_BIT];
  assign mode      = cplc_mode_t'(st.ctrl[`CPLC_CTRL_MODE_LSB +: 2]);
  assign man       = cplc_level_t'(st.ctrl[`CPLC_CTRL_MAN_LSB +: 2]);
  assign rate_sel  = st.dly[`CPLC_DLY_RATE_LSB +: 3];
  assign decay_sel = st.dly[`CPLC_DLY_DECAY_LSB +: 3];
  assign half_thr  = st.thr[`CPLC_THR_LSB +: 6];
  assign decay_ms  = decay_lookup(decay_sel);
  assign ms_tick   = st.pre == 24'(MS_CYCLES - 1);

  // level wanted by the selected mode
  always_comb begin
    want_full = 1'b0;
    want_half = 1'b0;
    case (mode)
      CPLC_MANUAL: begin
        want_full = man == CPLC_LVL_FULL;
        want_half = man == CPLC_LVL_HALF;
      end
      CPLC_TRK_OUT: begin
        want_half = out_vol_max <= OUT_VOL_THR;
        want_full = !want_half;
      end
      CPLC_TRK_DAC: begin
        want_half = dac_vol <= half_thr;
        want_full = !want_half;
      end
      CPLC_TRK_MAG: begin
        want_half = sig_mag <= half_thr;
        want_full = !want_half;
      end
      default: begin
        want_full = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    if (reg_wr) begin
      case (reg_addr)
        `CPLC_ADDR_CTRL: next_st.ctrl = reg_wdata & `CPLC_CTRL_MASK;
        `CPLC_ADDR_DLY:  next_st.dly  = reg_wdata & `CPLC_DLY_MASK;
        `CPLC_ADDR_THR:  next_st.thr  = reg_wdata & `CPLC_THR_MASK;
        default:         next_st.ctrl = st.ctrl;
      endcase
    end
    if (reg_rd) begin
      // read returns the stored value, unmapped addresses read zero
      case (reg_addr)
        `CPLC_ADDR_CTRL: next_st.rdata = st.ctrl;
        `CPLC_ADDR_DLY:  next_st.rdata = st.dly;
        `CPLC_ADDR_THR:  next_st.rdata = st.thr;
        default:         next_st.rdata = 8'h00;
      endcase
    end
    if (!pump_en) begin
      next_st.state   = CPLC_ST_STBY;
      next_st.pre     = 24'h0;
      next_st.ms_left = 10'h0;
    end else begin
      case (st.state)
        CPLC_ST_STBY: begin
          if (want_full) begin
            next_st.state = CPLC_ST_FULL;
          end else if (want_half) begin
            next_st.state = CPLC_ST_HALF;
          end
        end
        CPLC_ST_HALF: begin
          if (want_full) begin
            next_st.state = CPLC_ST_FULL;
          end else if (!want_half) begin
            next_st.state = CPLC_ST_STBY;
          end
        end
        CPLC_ST_FULL: begin
          if (want_half) begin
            next_st.pre     = 24'h0;
            next_st.ms_left = decay_ms;
            next_st.state   = (decay_ms == 10'h0) ? CPLC_ST_HALF : CPLC_ST_DECAY;
          end else if (!want_full) begin
            next_st.state = CPLC_ST_STBY;
          end
        end
        CPLC_ST_DECAY: begin
          if (want_full) begin
            next_st.state = CPLC_ST_FULL;
          end else if (!want_half) begin
            next_st.state = CPLC_ST_STBY;
          end else if (ms_tick) begin
            next_st.pre     = 24'h0;
            next_st.ms_left = st.ms_left - 10'h1;
            if (st.ms_left == 10'h1) begin
              next_st.state = CPLC_ST_HALF;
            end
          end else begin
            next_st.pre = st.pre + 24'h1;
          end
        end
        default: begin
          next_st.state = CPLC_ST_STBY;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{ctrl: `CPLC_CTRL_RST, dly: `CPLC_DLY_RST, thr: `CPLC_THR_RST,
              rdata: 8'h00, state: CPLC_ST_STBY, pre: 24'h0, ms_left: 10'h0};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // output level decoded straight from the state flops, so no glitches reach the pump
  always_comb begin
    case (st.state)
      CPLC_ST_HALF:  pump_level = CPLC_LVL_HALF;
      CPLC_ST_FULL:  pump_level = CPLC_LVL_FULL;
      CPLC_ST_DECAY: pump_level = CPLC_LVL_FULL;
      default:       pump_level = CPLC_LVL_STBY;
    endcase
  end

  assign pump_run            = pump_en;
  assign low_load_power_save = st.ctrl[`CPLC_CTRL_LP_BIT];
  assign analog_only         = pump_en && rate_sel >= `CPLC_RATE_STOP;
  assign reg_rdata           = st.rdata;

  cplc_rate_div u_rate_div (
    .clk      (clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .run      (pump_en && st.state != CPLC_ST_STBY),
    .rate_sel (rate_sel),
    .tick     (switch_tick)
  );

  sequence enter_decay_s;
    clk_en && st.state != CPLC_ST_DECAY ##1 st.state == CPLC_ST_DECAY;
  endsequence

  sequence stopped_s;
    (clk_en && rate_sel >= `CPLC_RATE_STOP) [*2];
  endsequence

  sequence last_ms_s;
    clk_en && pump_en && st.state == CPLC_ST_DECAY && want_half && ms_tick
    && st.ms_left == 10'h1;
  endsequence

  pump_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !pump_en |=> pump_level == CPLC_LVL_STBY && !switch_tick)
    else $error("pump level not standby while disabled");

  low_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && reg_wr && reg_addr == `CPLC_ADDR_CTRL
    |=> low_load_power_save == $past(reg_wdata[`CPLC_CTRL_LP_BIT]))
    else $error("low-load bit did not follow write");

  manual_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && pump_en && mode == CPLC_MANUAL && man == CPLC_LVL_FULL
    |=> pump_level == CPLC_LVL_FULL)
    else $error("manual full not applied");

  manual_stby_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && pump_en && mode == CPLC_MANUAL && man[1] == 1'b0
    |=> pump_level == CPLC_LVL_STBY)
    else $error("manual standby or reserved not standby");

  out_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && pump_en && mode == CPLC_TRK_OUT && out_vol_max > OUT_VOL_THR
    |=> pump_level == CPLC_LVL_FULL)
    else $error("output volume tracking missed full rail");

  dac_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && pump_en && mode == CPLC_TRK_DAC && dac_vol > half_thr
    |=> pump_level == CPLC_LVL_FULL)
    else $error("converter volume tracking missed full rail");

  mag_half_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && pump_en && mode == CPLC_TRK_MAG && sig_mag <= half_thr
    && st.state == CPLC_ST_HALF |=> pump_level == CPLC_LVL_HALF)
    else $error("magnitude tracking left half rail");

  decay_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    enter_decay_s |-> st.ms_left == decay_ms && st.pre == 24'h0
    && pump_level == CPLC_LVL_FULL)
    else $error("decay timer loaded wrongly");

  rise_fast_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && pump_en && st.state == CPLC_ST_DECAY && want_full
    |=> st.state == CPLC_ST_FULL)
    else $error("rise to full was delayed");

  rate_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    stopped_s |=> !switch_tick)
    else $error("switching clock ran in stop code");

  enable_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && reg_wr && reg_addr == `CPLC_ADDR_CTRL
    |=> pump_run == $past(reg_wdata[`CPLC_CTRL_EN_BIT]))
    else $error("pump run did not follow enable write");

  manual_half_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && pump_en && mode == CPLC_MANUAL && man == CPLC_LVL_HALF
    && (st.state == CPLC_ST_STBY || st.state == CPLC_ST_HALF)
    |=> pump_level == CPLC_LVL_HALF)
    else $error("manual half not applied");

  out_half_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && pump_en && mode == CPLC_TRK_OUT && out_vol_max <= OUT_VOL_THR
    && st.state == CPLC_ST_HALF |=> pump_level == CPLC_LVL_HALF)
    else $error("output volume tracking left half rail");

  mag_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && pump_en && mode == CPLC_TRK_MAG && sig_mag > half_thr
    |=> pump_level == CPLC_LVL_FULL)
    else $error("magnitude tracking missed full rail");

  decay_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && pump_en && st.state == CPLC_ST_FULL && want_half && decay_ms == 10'h0
    |=> pump_level == CPLC_LVL_HALF)
    else $error("zero decay did not drop at once");

  decay_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && pump_en && st.state == CPLC_ST_DECAY && want_half && st.ms_left > 10'h1
    |=> pump_level == CPLC_LVL_FULL)
    else $error("decay left full rail too early");

  decay_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    last_ms_s |=> pump_level == CPLC_LVL_HALF)
    else $error("decay did not end on half rail");

  standby_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && st.state == CPLC_ST_STBY |=> !switch_tick)
    else $error("switching clock ran in standby");
endmodule : cplc_pump_ctrl
`default_nettype wire

/* File: sim/cplc_pump_model.sv */
// behavioural model of the analog two-level charge pump on the far side
// assumes all inputs are registered outputs of the controller on clk
`timescale 1ns/100ps
`default_nettype none
module cplc_pump_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        pump_run,
  input  wire logic [1:0]  pump_level,
  input  wire logic        switch_tick,
  input  wire logic        analog_only,
  output logic      [15:0] period,
  output logic      [15:0] ticks,
  output logic      [1:0]  rail
);
  logic [15:0] gap;
  // a stopped pump delivers no rail whatever level is asked for
  assign rail = pump_run ? pump_level : 2'b00;
  // the spacing between switching edges is what the flying capacitor sees
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap    <= 16'h0000;
      period <= 16'h0000;
      ticks  <= 16'h0000;
    end else begin
      if (switch_tick) begin
        ticks <= ticks + 16'h0001;
      end
      // under analog feedback alone there is no nominal period to report
      if (analog_only) begin
        gap    <= 16'h0000;
        period <= 16'h0000;
      end else if (switch_tick) begin
        gap    <= 16'h0000;
        period <= gap + 16'h0001;
      end else begin
        gap    <= gap + 16'h0001;
      end
    end
  end
endmodule : cplc_pump_model
`default_nettype wire

/* File: sim/cplc_pump_ctrl_test.sv */
// self-checking bench for the charge pump level controller
// assumes the strobe register port and a shortened millisecond count
`timescale 1ns/100ps
`default_nettype none
module cplc_pump_ctrl_test;
  import cplc_pkg::*;
  localparam int MS = 4;
  logic        clk;
  logic        rst_n;
  logic        clk_en;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [5:0]  vol [3];
  logic        pump_run;
  logic        low_load_power_save;
  logic [1:0]  pump_level;
  logic        switch_tick;
  logic        analog_only;
  logic [15:0] period;
  logic [15:0] ticks;
  logic [1:0]  rail;
  logic [7:0]  rd_v;
  logic [15:0] t0;
  int          err_count;
  int          compares;
  int          n;
  int          ms_tab [8] = '{0, 2, 4, 16, 64, 128, 256, 512};
  int          n_tab  [5] = '{20, 40, 80, 160, 317};

  cplc_pump_ctrl #(.MS_CYCLES(MS)) u_dut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .out_vol_max(vol[1]), .dac_vol(vol[2]), .sig_mag(vol[0]),
    .pump_run(pump_run), .low_load_power_save(low_load_power_save),
    .pump_level(pump_level), .switch_tick(switch_tick), .analog_only(analog_only)
  );
  cplc_pump_model u_pump (
    .clk(clk), .rst_n(rst_n), .pump_run(pump_run), .pump_level(pump_level),
    .switch_tick(switch_tick), .analog_only(analog_only),
    .period(period), .ticks(ticks), .rail(rail)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  task automatic set_vol(input int m, input logic [5:0] d, input logic [5:0] o);
    @(posedge clk);
    for (int i = 0; i < 3; i++) vol[i] <= (i == m % 3) ? d : o;
  endtask : set_vol

  task automatic summarize;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial begin
    err_count = 0;
    compares  = 0;
    rst_n     = 1'b0;
    clk_en    = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    for (int i = 0; i < 3; i++) vol[i] = 6'h00;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    chk8(pump_run, 8'h00);
    chk8(low_load_power_save, 8'h01);
    chk8(pump_level, 8'h00);
    rd(8'hac, rd_v); chk8(rd_v, 8'h60);
    rd(8'had, rd_v); chk8(rd_v, 8'h11);
    rd(8'hae, rd_v); chk8(rd_v, 8'h0e);
    rd(8'h00, rd_v); chk8(rd_v, 8'h00);
    $display("test reset done");
    wr(8'had, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(8'hac, 8'h83 | 8'(m << 2));
      cyc(3);
      chk8(pump_level, (m == 3) ? 8'h03 : (m == 2) ? 8'h02 : 8'h00);
    end
    chk8(pump_run, 8'h01);
    chk8(low_load_power_save, 8'h00);
    rd(8'hac, rd_v); chk8(rd_v, 8'h8c);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(8'hac, 8'h00);
    clk_en <= 1'b1;
    rd(8'hac, rd_v); chk8(rd_v, 8'h8c);
    $display("test manual done");
    wr(8'hae, 8'h20);
    for (int m = 1; m < 4; m++) begin
      wr(8'hac, 8'h80 | 8'(m << 4));
      set_vol(m, 6'h3f, 6'h00); cyc(4); chk8(pump_level, 8'h03);
      set_vol(m, 6'h10, 6'h3f); cyc(4);
      chk8(pump_level, (m == 1) ? 8'h03 : 8'h02);
      set_vol(m, 6'h05, 6'h3f); cyc(4); chk8(pump_level, 8'h02);
    end
    $display("test tracking done");
    wr(8'hac, 8'h90);
    for (int c = 0; c < 8; c++) begin
      set_vol(1, 6'h3f, 6'h00);
      cyc(4);
      wr(8'had, 8'((c << 3) | 1));
      set_vol(1, 6'h05, 6'h00);
      n = 0;
      while (pump_level !== 2'b10 && n < 3000) begin
        cyc(1);
        n++;
      end
      chk8(n >= ms_tab[c] * MS && n <= ms_tab[c] * MS + 4, 8'h01);
      set_vol(1, 6'h3f, 6'h00);
      cyc(2);
      chk8(pump_level, 8'h03);
    end
    // a rise part way through a decay must restart the whole delay
    wr(8'had, 8'h19);
    set_vol(1, 6'h05, 6'h00);
    cyc(40);
    set_vol(1, 6'h3f, 6'h00);
    cyc(2);
    set_vol(1, 6'h05, 6'h00);
    cyc(50);
    chk8(pump_level, 8'h03);
    cyc(30);
    chk8(pump_level, 8'h02);
    $display("test decay done");
    wr(8'hac, 8'h8c);
    for (int r = 0; r < 5; r++) begin
      wr(8'had, 8'(r));
      cyc(3 * n_tab[r] + 10);
      chk8(period[7:0], 8'(n_tab[r]));
      chk8(period[15:8], 8'(n_tab[r] >> 8));
    end
    wr(8'had, 8'h05);
    cyc(2);
    t0 = ticks;
    cyc(400);
    chk8(ticks[7:0], t0[7:0]);
    chk8(analog_only, 8'h01);
    chk8(period[7:0], 8'h00);
    wr(8'had, 8'h01);
    wr(8'hac, 8'h0c);
    cyc(3);
    t0 = ticks;
    chk8(pump_run, 8'h00);
    chk8(rail, 8'h00);
    cyc(100);
    chk8(ticks[7:0], t0[7:0]);
    $display("test rate done");
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule : cplc_pump_ctrl_test
`default_nettype wire
